// ### logic/lvpx_pair.sv
/*
 * Pixel serializer pair: a transmitter that serialises a 21-bit pixel
 * word onto three lanes plus a forwarded clock, and a receiver that
 * rebuilds the word and a panel shift clock.
 * Assumes ref_clk is the serial bit clock (seven per shift period)
 * and link_clk the received bit clock, unrelated in phase.
 */
// Behaviour
// - The transmitter takes a 21-bit word of 6 red, 6 green, 6 blue and 3 control bits.
// - The control bits are line sync, frame sync and pixel valid, carried like colour.
// - The word is sampled one ref_clk cycle before the falling shift clock edge and must be stable there.
// - The serial word leaves on three data lanes.
// - Each lane carries seven slots per shift period, all 21 bits every period.
// - Each input bit has one fixed lane and slot.
// - The shift clock is forwarded on its own output beside the lanes.
// - With power-down low the transmitter releases its lanes and forwarded clock; the shift clock keeps running.
// - The receiver takes three data lanes and one forwarded clock.
// - The receiver rebuilds the 21-bit word with the same grouping.
// - The receiver makes a shift clock whose falling edge marks valid data.
// - With power-down low the receiver holds its word at its last value and its shift clock low.
`timescale 1ns/1ps
`include "lvpx_params.svh"

module lvpx_pair (
    // System clock, enable and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Transmitter parallel side
    input wire lvpx_pkg::lvpx_pixel_t parallel_pixel_in,
    input wire logic tx_power_down_n,
    output logic pixel_shift_clk_in,
    // Transmitter serial side
    output lvpx_pkg::lvpx_lanes_t serial_lane_out,
    output logic serial_lane_oe,
    output logic forwarded_clk_out,
    output logic forwarded_clk_oe,
    // Receiver link side
    input wire logic link_clk,
    input wire lvpx_pkg::lvpx_lanes_t serial_lane_in,
    input wire logic forwarded_clk_in,
    // Receiver panel side
    input wire logic rx_power_down_n,
    output lvpx_pkg::lvpx_pixel_t parallel_pixel_out,
    output logic pixel_shift_clk_out
);

    // ------------------------------------------------------------
    // Reset release, one copy per domain
    // ------------------------------------------------------------
    logic rst_s1_r, rst_n_r;
    logic lrst_s1_r, link_rst_n_r;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_r <= 1'h0;
            rst_n_r <= 1'h0;
        end
        else
        begin
            rst_s1_r <= 1'h1;
            rst_n_r <= rst_s1_r;
        end
    end

    always_ff @(posedge link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lrst_s1_r <= 1'h0;
            link_rst_n_r <= 1'h0;
        end
        else
        begin
            lrst_s1_r <= 1'h1;
            link_rst_n_r <= lrst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers on ref_clk
    // ------------------------------------------------------------
    logic txpd_s1_r, txpd_s2_r, rxpd_s1_r, rxpd_s2_r;
    lvpx_pkg::lvpx_pixel_t pix_s1_r, pix_s2_r;

    // Pixel pins are synchronised bitwise; the controller keeps them
    // stable around the capture edge, so no bit is torn there
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            txpd_s1_r <= 1'h0;
            txpd_s2_r <= 1'h0;
            rxpd_s1_r <= 1'h0;
            rxpd_s2_r <= 1'h0;
            pix_s1_r <= `LVPX_PIX_RESET;
            pix_s2_r <= `LVPX_PIX_RESET;
        end
        else if (clk_en)
        begin
            txpd_s1_r <= tx_power_down_n;
            txpd_s2_r <= txpd_s1_r;
            rxpd_s1_r <= rx_power_down_n;
            rxpd_s2_r <= rxpd_s1_r;
            pix_s1_r <= parallel_pixel_in;
            pix_s2_r <= pix_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic shift_gen;

    lvpx_tx_lanes u_tx (
        .ref_clk(ref_clk),
        .rst_n(rst_n_r),
        .clk_en(clk_en),
        .pixel_in(pix_s2_r),
        .power_down_n(txpd_s2_r),
        .serial_lane_out(serial_lane_out),
        .serial_lane_oe(serial_lane_oe),
        .forwarded_clk_out(forwarded_clk_out),
        .forwarded_clk_oe(forwarded_clk_oe),
        .pixel_shift_clk_gen(shift_gen)
    );

    // Shift clock handed to the controller; its fall is the strobe
    logic shift_r, shift_nxt;

    always_comb
    begin
        shift_nxt = shift_gen;
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            shift_r <= 1'h0;
        end
        else if (clk_en)
        begin
            shift_r <= shift_nxt;
        end
    end

    assign pixel_shift_clk_in = shift_r;

    // ------------------------------------------------------------
    // Receiver deserialiser on the link clock
    // ------------------------------------------------------------
    logic [`LVPX_WORD_BITS-1:0] rx_word;
    logic rx_tgl;

    lvpx_rx_lanes u_rx (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n_r),
        .serial_lane_in(serial_lane_in),
        .forwarded_clk_in(forwarded_clk_in),
        .word_out(rx_word),
        .word_tgl(rx_tgl)
    );

    // ------------------------------------------------------------
    // Word crossing: toggle through two flops, then the word,
    // which stays stable for the rest of its frame, is taken
    // ------------------------------------------------------------
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    lvpx_pkg::lvpx_pixel_t pout_r, pout_nxt;
    logic sclk_r, sclk_nxt;
    logic [`LVPX_SLOT_W-1:0] hold_r, hold_nxt;

    always_comb
    begin
        pout_nxt = pout_r;
        sclk_nxt = sclk_r;
        hold_nxt = hold_r;
        if (tgl_s2_r != tgl_s3_r)
        begin
            // New word: data changes on the same edge as the panel clock rise
            if (rxpd_s2_r)
            begin
                pout_nxt = rx_word;
            end
            sclk_nxt = 1'h1;
            hold_nxt = 3'h0;
        end
        else if (hold_r != `LVPX_LAST_SLOT)
        begin
            hold_nxt = hold_r + 3'h1;
            // Fall mid-frame, data already settled
            if (hold_r == 3'h3)
            begin
                sclk_nxt = 1'h0;
            end
        end
        if (!rxpd_s2_r)
        begin
            sclk_nxt = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tgl_s1_r <= 1'h0;
            tgl_s2_r <= 1'h0;
            tgl_s3_r <= 1'h0;
            pout_r <= `LVPX_PIX_RESET;
            sclk_r <= 1'h0;
            hold_r <= `LVPX_LAST_SLOT;
        end
        else if (clk_en)
        begin
            tgl_s1_r <= rx_tgl;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
            pout_r <= pout_nxt;
            sclk_r <= sclk_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign parallel_pixel_out = pout_r;
    assign pixel_shift_clk_out = sclk_r;

endmodule : lvpx_pair

// ### logic/lvpx_params.svh
/*
 * Constants of the pixel serializer pair: word layout, lane count,
 * slot count and the serial clock ratio.
 * Included by bare name by the package and the design modules.
 */
`ifndef LVPX_PARAMS_SVH
`define LVPX_PARAMS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define LVPX_COLOR_BITS 6
`define LVPX_WORD_BITS 21
`define LVPX_LANES 3
`define LVPX_SLOTS 7
`define LVPX_CTRL_BITS 3
`define LVPX_SLOT_W 3
`define LVPX_LAST_SLOT 3'h6
`define LVPX_PIX_RESET 21'h000000

`endif

// ### logic/lvpx_pkg.sv
/*
 * Types of the pixel serializer pair.
 * Assumes lvpx_params.svh is on the include path.
 */
`include "lvpx_params.svh"

package lvpx_pkg;

    // ------------------------------------------------------------
    // Parallel pixel word
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`LVPX_COLOR_BITS-1:0] red;
        logic [`LVPX_COLOR_BITS-1:0] green;
        logic [`LVPX_COLOR_BITS-1:0] blue;
        logic line_sync;
        logic frame_sync;
        logic pixel_valid;
    } lvpx_pixel_t;

    // ------------------------------------------------------------
    // Serial lanes, one bit per lane per slot
    // ------------------------------------------------------------
    typedef logic [`LVPX_LANES-1:0] lvpx_lanes_t;

    // Fixed mapping: lane l, slot s carries word bit l*7+s
    function automatic logic [4:0] lvpx_bit_index(
        input logic [1:0] lane,
        input logic [2:0] slot
    );
        lvpx_bit_index = 5'(lane) * 5'h07 + 5'(slot);
    endfunction : lvpx_bit_index

endpackage : lvpx_pkg

// ### logic/lvpx_rx_lanes.sv
/*
 * Receive deserialiser on the link clock domain. The link clock is the
 * serial bit clock; the forwarded clock is sampled as data on it and
 * its falling edge marks slot 4 of the frame being sent.
 * Assumes the far end keeps the same lane and slot mapping.
 */
`timescale 1ns/1ps
`include "lvpx_params.svh"

module lvpx_rx_lanes (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst_n,
    // Serial side
    input wire lvpx_pkg::lvpx_lanes_t serial_lane_in,
    input wire logic forwarded_clk_in,
    // Word out, toggle marks a new word
    output logic [`LVPX_WORD_BITS-1:0] word_out,
    output logic word_tgl
);

    logic fclk_d_r, fclk_d_nxt;
    logic [`LVPX_SLOT_W-1:0] slot_r, slot_nxt;
    logic [`LVPX_WORD_BITS-1:0] acc_r, acc_nxt;
    logic [`LVPX_WORD_BITS-1:0] word_r, word_nxt;
    logic tgl_r, tgl_nxt;
    logic seen_r, seen_nxt;
    logic [4:0] idx;

    // ------------------------------------------------------------
    // Frame alignment and assembly
    // ------------------------------------------------------------
    always_comb
    begin
        idx = 5'h00;
        fclk_d_nxt = forwarded_clk_in;
        // High-to-low on the forwarded clock: this bit is slot 4
        if (fclk_d_r && !forwarded_clk_in)
        begin
            slot_nxt = 3'h5;
        end
        else
        begin
            slot_nxt = (slot_r == `LVPX_LAST_SLOT) ? 3'h0 : slot_r + 3'h1;
        end
        acc_nxt = acc_r;
        for (int l = 0; l < `LVPX_LANES; l++)
        begin
            idx = lvpx_pkg::lvpx_bit_index(2'(l), slot_r);
            acc_nxt[idx] = serial_lane_in[l];
        end
        word_nxt = word_r;
        tgl_nxt = tgl_r;
        seen_nxt = seen_r;
        // A frame with no forwarded fall is not framed, so an idle link
        // never hands garbage to the panel side
        if (slot_r == `LVPX_LAST_SLOT)
        begin
            if (seen_r)
            begin
                word_nxt = acc_nxt;
                tgl_nxt = !tgl_r;
            end
            seen_nxt = 1'h0;
        end
        // Set wins over the frame-end clear
        if (fclk_d_r && !forwarded_clk_in)
        begin
            seen_nxt = 1'h1;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            fclk_d_r <= 1'h0;
            slot_r <= 3'h0;
            acc_r <= `LVPX_PIX_RESET;
            word_r <= `LVPX_PIX_RESET;
            tgl_r <= 1'h0;
            seen_r <= 1'h0;
        end
        else
        begin
            fclk_d_r <= fclk_d_nxt;
            slot_r <= slot_nxt;
            acc_r <= acc_nxt;
            word_r <= word_nxt;
            tgl_r <= tgl_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign word_out = word_r;
    assign word_tgl = tgl_r;

endmodule : lvpx_rx_lanes

// ### logic/lvpx_tx_lanes.sv
/*
 * Transmit serialiser: captures a word at the slot wrap, two slots after
 * the shift clock falls, and shifts it out, seven slots per lane per shift period.
 * Runs on the serial bit clock ref_clk, seven times the shift rate;
 * the shift clock is derived here, so no second domain.
 */
`timescale 1ns/1ps
`include "lvpx_params.svh"

module lvpx_tx_lanes (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Parallel side
    input wire lvpx_pkg::lvpx_pixel_t pixel_in,
    input wire logic power_down_n,
    // Serial side
    output lvpx_pkg::lvpx_lanes_t serial_lane_out,
    output logic serial_lane_oe,
    output logic forwarded_clk_out,
    output logic forwarded_clk_oe,
    output logic pixel_shift_clk_gen
);

    logic [`LVPX_SLOT_W-1:0] slot_r, slot_nxt;
    logic [`LVPX_WORD_BITS-1:0] word_r, word_nxt;
    lvpx_pkg::lvpx_lanes_t lane_r, lane_nxt;
    logic fclk_r, fclk_nxt;
    logic oe_r, oe_nxt;

    // ------------------------------------------------------------
    // Slot counter, capture and shift
    // ------------------------------------------------------------
    always_comb
    begin
        slot_nxt = (slot_r == `LVPX_LAST_SLOT) ? 3'h0 : slot_r + 3'h1;
        word_nxt = word_r;
        // Shift clock falls two slots before the slot wrap where the word is captured
        if (slot_r == `LVPX_LAST_SLOT)
        begin
            word_nxt = pixel_in;
        end
        for (int l = 0; l < `LVPX_LANES; l++)
        begin
            lane_nxt[l] = word_r[lvpx_pkg::lvpx_bit_index(2'(l), slot_r)];
        end
        // Clock high for slots 0..3, low for 4..6
        fclk_nxt = (slot_r < 3'h4);
        oe_nxt = power_down_n;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_r <= 3'h0;
            word_r <= `LVPX_PIX_RESET;
            lane_r <= 3'h0;
            fclk_r <= 1'h0;
            oe_r <= 1'h0;
        end
        else if (clk_en)
        begin
            slot_r <= slot_nxt;
            word_r <= word_nxt;
            lane_r <= lane_nxt;
            fclk_r <= fclk_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign serial_lane_out = lane_r;
    assign serial_lane_oe = oe_r;
    assign forwarded_clk_out = fclk_r;
    assign forwarded_clk_oe = oe_r;
    assign pixel_shift_clk_gen = fclk_r;

endmodule : lvpx_tx_lanes

// ### verif/lvpx_link_src.sv
/* Far-end transmitter model on the link clock.
 * Assumes word is held by the bench; latched at each frame start. */
`timescale 1ns/1ps

module lvpx_link_src (
    // Link clock
    input wire logic link_clk,
    // Word source
    input wire logic [20:0] word,
    input wire logic run,
    // Serial side
    output lvpx_pkg::lvpx_lanes_t lanes,
    output logic fclk
);
    logic [2:0] slot = 3'h0;
    logic live = 1'b0;
    logic tgl = 1'b0;
    logic [20:0] wr = 21'h000000;

    // Latching at slot 6 keeps a frame whole when the bench changes word
    always @(posedge link_clk)
    begin
        tgl <= ~tgl;
        if (slot == 3'h6)
        begin
            slot <= 3'h0;
            live <= run;
            wr <= word;
        end
        else
            slot <= slot + 3'h1;
    end

    assign fclk = live && (slot < 3'h4);
    // Idle lanes toggle so a stale value cannot pass for data
    assign lanes = live ? {wr[5'd14 + 5'(slot)], wr[5'd7 + 5'(slot)],
        wr[5'(slot)]} : {3{tgl}};
endmodule : lvpx_link_src

// ### verif/lvpx_pair_properties.sv
/* Port checker for the pixel serializer pair.
 * Assumes one ref_clk domain view of the top ports; bound below. */
`timescale 1ns/1ps

module lvpx_pair_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Transmitter pins
    input wire logic tx_power_down_n,
    input wire logic pixel_shift_clk_in,
    input wire logic serial_lane_oe,
    input wire logic forwarded_clk_out,
    input wire logic forwarded_clk_oe,
    // Receiver pins
    input wire logic rx_power_down_n,
    input wire lvpx_pkg::lvpx_pixel_t parallel_pixel_out,
    input wire logic pixel_shift_clk_out
);
    // ------------------------------------------------------------
    // Shapes of the clocks, output enables and power-down behaviour
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn || !clk_en);
    sequence s_fwd_hi;
        forwarded_clk_out [*4];
    endsequence
    sequence s_fwd_lo;
        !forwarded_clk_out [*3];
    endsequence
    sequence s_rx_hi;
        pixel_shift_clk_out [*4];
    endsequence

    a_oe_pair: assert property (forwarded_clk_oe == serial_lane_oe)
        else $error("clock and lane enables differ");
    a_fwd_shape: assert property ($rose(forwarded_clk_out) |->
        s_fwd_hi ##1 s_fwd_lo ##1 forwarded_clk_out)
        else $error("forwarded clock not 4 high 3 low");
    a_shift_shape: assert property ($fell(pixel_shift_clk_in) |->
        !pixel_shift_clk_in [*3] ##1 pixel_shift_clk_in [*4]
        ##1 !pixel_shift_clk_in)
        else $error("shift clock not 3 low 4 high");
    a_pd_drop: assert property ($fell(tx_power_down_n) |->
        ##[1:4] !serial_lane_oe)
        else $error("lanes still driven in power-down");
    a_pd_hold: assert property (!tx_power_down_n [*4] |->
        !serial_lane_oe && !forwarded_clk_oe)
        else $error("output enabled during power-down");
    a_pd_back: assert property ($rose(tx_power_down_n) |->
        ##[1:4] serial_lane_oe)
        else $error("lanes not driven after power-up");
    a_rx_hold: assert property (!rx_power_down_n [*4] |->
        $stable(parallel_pixel_out))
        else $error("receiver word moved in power-down");
    a_rx_clk_low: assert property (!rx_power_down_n [*4] |->
        !pixel_shift_clk_out)
        else $error("receiver shift clock runs in power-down");
    a_rx_upd: assert property (!$stable(parallel_pixel_out) |->
        $rose(pixel_shift_clk_out))
        else $error("word changed off the shift clock rise");
    a_rx_pulse: assert property (disable iff (!resetn || !rx_power_down_n)
        $rose(pixel_shift_clk_out) |-> s_rx_hi ##1 !pixel_shift_clk_out)
        else $error("receiver shift clock not 4 high");
endmodule : lvpx_pair_chk

bind lvpx_pair lvpx_pair_chk chk_u (.ref_clk, .resetn, .clk_en,
    .tx_power_down_n, .pixel_shift_clk_in, .serial_lane_oe,
    .forwarded_clk_out, .forwarded_clk_oe, .rx_power_down_n,
    .parallel_pixel_out, .pixel_shift_clk_out);

// ### verif/tb_lvpx_pair.sv
/* Self-checking bench of the pixel serializer pair.
 * Assumes the checker is bound and the link source model is compiled. */
`timescale 1ns/1ps

module tb_lvpx_pair;
    logic ref_clk, link_clk, resetn, tx_pd_n, rx_pd_n, run;
    lvpx_pkg::lvpx_pixel_t pix_in, pix_out;
    lvpx_pkg::lvpx_lanes_t lanes_o, lanes_i;
    logic sclk_in, oe, fclk_o, foe, fclk_i, sclk_o;
    logic [20:0] word;
    int err_count = 0;
    int n_tests = 0;
    logic [20:0] tab [3] = '{21'h1FFFFF, 21'h0AAAAA, 21'h12D0C3};

    lvpx_pair dut_u (.ref_clk, .resetn, .clk_en(1'b1),
        .parallel_pixel_in(pix_in), .tx_power_down_n(tx_pd_n),
        .pixel_shift_clk_in(sclk_in), .serial_lane_out(lanes_o),
        .serial_lane_oe(oe), .forwarded_clk_out(fclk_o),
        .forwarded_clk_oe(foe), .link_clk, .serial_lane_in(lanes_i),
        .forwarded_clk_in(fclk_i), .rx_power_down_n(rx_pd_n),
        .parallel_pixel_out(pix_out), .pixel_shift_clk_out(sclk_o));
    lvpx_link_src src_u (.link_clk, .word, .run, .lanes(lanes_i),
        .fclk(fclk_i));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task chk(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait so a dead clock output ends the run
    task wait_sig(input bit rx, input logic lvl);
        int i;
        for (i = 0; i < 60; i++)
        begin
            if ((rx ? sclk_o : fclk_o) === lvl)
                return;
            tick(1);
        end
        err_count++;
        $display("Error at %0t: got %h exp %h", $time, ~lvl, lvl);
        give_verdict();
    endtask : wait_sig

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task tx_word(input logic [20:0] w);
        logic [20:0] got;
        int s;
        @(posedge ref_clk) pix_in <= w;
        tick(21);
        wait_sig(0, 1'b0);
        wait_sig(0, 1'b1);
        for (s = 0; s < 7; s++)
        begin
            got[s] = lanes_o[0];
            got[7 + s] = lanes_o[1];
            got[14 + s] = lanes_o[2];
            if (s < 6)
                tick(1);
        end
        chk(got, w);
        chk({19'h0, oe, foe}, 21'h000003);
    endtask : tx_word

    task rx_word(input logic [20:0] w);
        @(posedge ref_clk) word <= w;
        tick(40);
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        chk(pix_out, w);
    endtask : rx_word

    task tx_pd;
        @(posedge ref_clk) tx_pd_n <= 1'b0;
        tick(6);
        chk({19'h0, oe, foe}, 21'h000000);
        @(posedge ref_clk) tx_pd_n <= 1'b1;
        tick(6);
        chk({19'h0, oe, foe}, 21'h000003);
    endtask : tx_pd

    task rx_pd;
        @(posedge ref_clk) rx_pd_n <= 1'b0;
        tick(5);
        @(posedge ref_clk) word <= tab[0];
        tick(40);
        chk(pix_out, tab[2]);
        chk({20'h0, sclk_o}, 21'h000000);
        @(posedge ref_clk) rx_pd_n <= 1'b1;
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        chk(pix_out, tab[0]);
    endtask : rx_pd

    // Link idles: lanes toggle but no forwarded edge, so no word is framed
    task link_idle;
        @(posedge ref_clk) run <= 1'b0;
        word <= tab[1];
        tick(40);
        chk(pix_out, tab[0]);
        @(posedge ref_clk) run <= 1'b1;
        rx_word(tab[1]);
    endtask : link_idle

    initial
    begin
        resetn = 1'b0;
        tx_pd_n = 1'b1;
        rx_pd_n = 1'b1;
        run = 1'b1;
        pix_in = '0;
        word = 21'h000000;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(6);
        foreach (tab[i])
        begin
            tx_word(tab[i]);
            rx_word(tab[i]);
        end
        tx_pd();
        rx_pd();
        link_idle();
        give_verdict();
    end
endmodule : tb_lvpx_pair
